// ---- src/rsd_pkg.sv ----
// package: constants and types for the relay switch serial diagnosis block
`default_nettype none
package rsd_pkg;

  localparam int RSD_CHANNELS = 8;
  localparam int RSD_WORD_BITS = 16;
  localparam int RSD_CLK_PERIOD_NS = 8;

  // open-load delay window, microseconds
  localparam int RSD_OL_DELAY_MIN_US = 30;
  localparam int RSD_OL_DELAY_MAX_US = 200;
  // over-load shutdown delay window, microseconds
  localparam int RSD_OVL_DELAY_MIN_US = 3;
  localparam int RSD_OVL_DELAY_MAX_US = 50;
  // chosen points inside the windows: least time, rounded up
  localparam int RSD_OL_DELAY_CYC = (RSD_OL_DELAY_MIN_US * 1000 + RSD_CLK_PERIOD_NS - 1)
    / RSD_CLK_PERIOD_NS;
  localparam int RSD_OVL_DELAY_CYC = (RSD_OVL_DELAY_MIN_US * 1000 + RSD_CLK_PERIOD_NS - 1)
    / RSD_CLK_PERIOD_NS;
  localparam int RSD_DLY_W = 16;

  // bit count checks
  localparam int RSD_BYTE_BITS = 8;
  localparam int RSD_CNT_W = 8;

  localparam logic [15:0] RSD_CFG_RESET = 16'hffff;
  localparam logic RSD_TER_RESET = 1'b1;

  // wishbone map (byte addresses)
  localparam logic [7:0] RSD_ADDR_STATUS = 8'h00;
  localparam logic [7:0] RSD_ADDR_CONFIG = 8'h04;
  localparam logic [7:0] RSD_ADDR_FLAGS = 8'h08;
  localparam logic [7:0] RSD_ADDR_OUTPUT = 8'h0c;

  typedef enum logic [1:0] {
    RSD_MODE_STANDBY = 2'h0,
    RSD_MODE_INPUT = 2'h1,
    RSD_MODE_ON = 2'h2,
    RSD_MODE_OFF = 2'h3
  } rsd_mode_t;

  // analog sense inputs of one channel
  typedef struct packed {
    logic open_load;
    logic over_load;
    logic over_temp;
  } rsd_sense_t;

  // per-channel drive outputs
  typedef struct packed {
    logic switch_on;
    logic diag_current;
  } rsd_drive_t;

endpackage
`default_nettype wire

// ---- src/rsd_channel.sv ----
// one output channel: mode decode, protection and diagnosis flags
`timescale 1ns/1ps
`default_nettype none
module rsd_channel
  import rsd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic [1:0] mode_i,
  input wire logic input_pin_i,
  input wire rsd_sense_t sense_i,
  // results
  output rsd_drive_t drive_o,
  output logic open_load_flag_o,
  output logic protection_fault_flag_o
);

  logic standby;
  logic want_on;
  logic on_now;
  logic [RSD_DLY_W-1:0] ol_cnt_q;
  logic [RSD_DLY_W-1:0] ovl_cnt_q;
  logic ol_q;
  logic pf_q;
  logic ol_set;
  logic ovl_trip;

  assign standby = (mode_i == RSD_MODE_STANDBY);
  always_comb begin
    case (mode_i)
      RSD_MODE_INPUT: want_on = input_pin_i;
      RSD_MODE_ON: want_on = 1'b1;
      default: want_on = 1'b0;
    endcase
  end
  // latched fault keeps channel off until standby clears it
  assign on_now = want_on && !pf_q;

  // open load timing only in the off state with diagnosis current
  always_ff @(posedge clk_i) begin
    if (rst_i || standby || on_now || !sense_i.open_load) begin
      ol_cnt_q <= '0;
    end else if (ol_cnt_q != RSD_DLY_W'(RSD_OL_DELAY_CYC)) begin
      ol_cnt_q <= ol_cnt_q + 1'b1;
    end
  end
  assign ol_set = (ol_cnt_q == RSD_DLY_W'(RSD_OL_DELAY_CYC));

  always_ff @(posedge clk_i) begin
    if (rst_i || !on_now || !sense_i.over_load) begin
      ovl_cnt_q <= '0;
    end else if (ovl_cnt_q != RSD_DLY_W'(RSD_OVL_DELAY_CYC)) begin
      ovl_cnt_q <= ovl_cnt_q + 1'b1;
    end
  end
  assign ovl_trip = (ovl_cnt_q == RSD_DLY_W'(RSD_OVL_DELAY_CYC));

  always_ff @(posedge clk_i) begin
    if (rst_i || standby) begin
      ol_q <= 1'b0;
    end else if (ol_set) begin
      ol_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || standby) begin
      pf_q <= 1'b0;
    end else if (sense_i.over_temp || ovl_trip) begin
      pf_q <= 1'b1;
    end
  end

  assign drive_o.switch_on = on_now;
  assign drive_o.diag_current = !standby && !on_now;
  assign open_load_flag_o = ol_q;
  assign protection_fault_flag_o = pf_q;

endmodule
`default_nettype wire

// ---- src/rsd_top.sv ----
// top: serial slave, configuration, diagnosis word and wishbone view
//
// Overview of operation
// - each channel keeps a sticky fault flag for over load or over temperature.
// - off channel with diagnosis sets open-load flag after the open-load delay.
// - both channel flags clear only on reset or while that channel is in standby.
// - open-load detection runs only in the off state.
// - over temperature sets fault flag and switches an active channel off.
// - over load switches channel off after the over-load delay and flags it.
// - select high: clock and data ignored, serial output high impedance.
// - select falling loads the diagnosis flags into the shift register.
// - before first rising clock, output is transfer error OR serial input.
// - any reset sets the transfer error flag.
// - input sampled on falling clock edge, output shifted on rising edge.
// - words travel most significant bit first both ways.
// - select rising commits only if clock count is multiple of 8, at least 16.
// - one bit shifts per clock; after 16 the old word has left.
// - transfer error reads 0 after a valid transfer, 1 otherwise or after reset.
// - two-bit mode: standby, follow input, forced on, forced off with diagnosis.
// - outgoing word: per channel open-load in odd bit, fault in even bit.
// - configuration resets to all ones.
`timescale 1ns/1ps
`default_nettype none
module rsd_top
  import rsd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // serial link pins
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // channel side
  input wire logic [RSD_CHANNELS-1:0] input_pin_i,
  input wire rsd_sense_t [RSD_CHANNELS-1:0] sense_i,
  output rsd_drive_t [RSD_CHANNELS-1:0] drive_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] cs_sync_q;
  logic [1:0] clk_sync_q;
  logic [1:0] di_sync_q;
  logic cs_n_q;
  logic sclk_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_sync_q <= 2'h3;
      clk_sync_q <= 2'h0;
      di_sync_q <= 2'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], select_n_i};
      clk_sync_q <= {clk_sync_q[0], sclk_i};
      di_sync_q <= {di_sync_q[0], sdi_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_n_q <= cs_sync_q[1];
      sclk_q <= clk_sync_q[1];
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic active;
  logic clk_rise;
  logic clk_fall;

  assign cs_fall = cs_n_q && !cs_sync_q[1];
  assign cs_rise = !cs_n_q && cs_sync_q[1];
  assign active = !cs_sync_q[1] && !cs_n_q;
  // edges ignored while deselected
  assign clk_rise = active && !sclk_q && clk_sync_q[1];
  assign clk_fall = active && sclk_q && !clk_sync_q[1];

  // ==========================================================
  // channel pin and sense synchronisers
  logic [RSD_CHANNELS-1:0] pin_meta_q;
  logic [RSD_CHANNELS-1:0] pin_sync_q;
  rsd_sense_t [RSD_CHANNELS-1:0] sense_meta_q;
  rsd_sense_t [RSD_CHANNELS-1:0] sense_sync_q;

  // pins and sense lines are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      sense_meta_q <= '0;
      sense_sync_q <= '0;
    end else begin
      pin_meta_q <= input_pin_i;
      pin_sync_q <= pin_meta_q;
      sense_meta_q <= sense_i;
      sense_sync_q <= sense_meta_q;
    end
  end

  // ==========================================================
  // channels
  logic [15:0] cfg_q;
  logic [RSD_CHANNELS-1:0] ol_flag;
  logic [RSD_CHANNELS-1:0] pf_flag;
  logic [15:0] diag_word;

  genvar g;
  generate
    for (g = 0; g < RSD_CHANNELS; g++) begin : g_ch
      rsd_channel u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(cfg_q[2*g+1 -: 2]),
        .input_pin_i(pin_sync_q[g]),
        .sense_i(sense_sync_q[g]),
        .drive_o(drive_o[g]),
        .open_load_flag_o(ol_flag[g]),
        .protection_fault_flag_o(pf_flag[g])
      );
      assign diag_word[2*g+1] = ol_flag[g];
      assign diag_word[2*g] = pf_flag[g];
    end
  endgenerate

  // ==========================================================
  // shift register and bit count
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [RSD_CNT_W-1:0] cnt_q;
  logic cnt_wrap_q;
  logic seen_rise_q;
  logic ter_q;
  logic sdo_q;
  logic valid_len;

  // shift in on falling edge, out on rising edge
  assign shift_d = {shift_q[14:0], di_sync_q[1]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= '0;
    end else if (cs_fall) begin
      shift_q <= diag_word;
    end else if (clk_fall) begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cs_fall) begin
      cnt_q <= '0;
      cnt_wrap_q <= 1'b0;
    end else if (clk_fall) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == '1) begin
        cnt_wrap_q <= 1'b1;
      end
    end
  end

  // counts falling edges; at select rise the register holds the last 16 bits
  assign valid_len = (cnt_q[2:0] == 3'h0)
    && (cnt_wrap_q || cnt_q >= RSD_CNT_W'(RSD_WORD_BITS));

  always_ff @(posedge clk_i) begin
    if (rst_i || cs_fall) begin
      seen_rise_q <= 1'b0;
    end else if (clk_rise) begin
      seen_rise_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      sdo_q <= diag_word[15];
    end else if (clk_rise) begin
      sdo_q <= shift_q[15];
    end
  end

  // ==========================================================
  // configuration and transfer error
  logic wb_cfg_we;
  logic [15:0] wb_cfg_val;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= RSD_CFG_RESET;
    end else if (cs_rise && valid_len) begin
      cfg_q <= shift_q;
    end else if (wb_cfg_we) begin
      cfg_q <= wb_cfg_val;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ter_q <= RSD_TER_RESET;
    end else if (cs_rise) begin
      ter_q <= !valid_len;
    end
  end

  // ==========================================================
  // serial output pin
  always_comb begin
    sdo_oe_o = active;
    if (!seen_rise_q) begin
      sdo_o = ter_q | di_sync_q[1];
    end else begin
      sdo_o = sdo_q;
    end
  end

  // ==========================================================
  // wishbone slave
  logic wb_req;
  logic ack_q;
  logic [31:0] rd_q;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  // write lands at the edge that completes the cycle
  assign wb_cfg_we = wb_cyc_i && wb_stb_i && ack_q && wb_we_i
    && (wb_adr_i == RSD_ADDR_CONFIG);
  assign wb_cfg_val = {wb_sel_i[1] ? wb_dat_i[15:8] : cfg_q[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : cfg_q[7:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        RSD_ADDR_STATUS: rd_q <= {29'h0, active, seen_rise_q, ter_q};
        RSD_ADDR_CONFIG: rd_q <= {16'h0, cfg_q};
        RSD_ADDR_FLAGS: rd_q <= {16'h0, diag_word};
        RSD_ADDR_OUTPUT: rd_q <= {16'h0, drive_o};
        default: rd_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

endmodule
`default_nettype wire

// ---- bench/rsd_top_sva.sv ----
// checker: serial link and bus assertions for rsd_top
`timescale 1ns/1ps
`default_nettype none
module rsd_top_sva (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic sclk_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic fresh_q;
  logic sclk_q;
  logic req_q;
  // ==========================================
  // helpers
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk_i;
    req_q <= wb_cyc_i && wb_stb_i;
  end
  // set until the first clock rise of a frame after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fresh_q <= 1'b1;
    end else if (!select_n_i && sclk_i && !sclk_q) begin
      fresh_q <= 1'b0;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_sel_fall;
    $fell(select_n_i);
  endsequence
  sequence s_sclk_high;
    (!select_n_i && sclk_i) [*8];
  endsequence
  a_oe_idle: assert property (select_n_i [*5] |-> !sdo_oe_o)
    else $error("sdo driven while deselected");
  a_oe_start: assert property (s_sel_fall |-> ##[1:6] sdo_oe_o)
    else $error("sdo not driven after select");
  a_oe_stop: assert property ($rose(select_n_i) |-> ##[1:6] !sdo_oe_o)
    else $error("sdo not released");
  a_sdo_hold: assert property (s_sclk_high |-> $stable(sdo_o))
    else $error("sdo moved while clock high");
  a_ter_first: assert property (fresh_q && !select_n_i && !sclk_i && sdo_oe_o |-> sdo_o)
    else $error("error flag not shown after reset");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_reply: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_source: assert property (wb_ack_o |-> req_q && wb_cyc_i)
    else $error("ack without request");
endmodule
bind rsd_top rsd_top_sva i_rsd_top_sva (.clk_i, .rst_i, .select_n_i, .sclk_i, .sdo_o,
  .sdo_oe_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// ---- bench/rsd_spi_master.sv ----
// partner: serial master model driving the link
`timescale 1ns/1ps
`default_nettype none
module rsd_spi_master (
  // clock
  input wire logic clk_i,
  // from slave
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // to slave
  output var logic select_n_o,
  output var logic sclk_o,
  output var logic sdi_o
);
  initial begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // half link period is 10 clocks; win is sdo before first rise
  task automatic xfer(input int n, input logic [31:0] din, output logic [31:0] dout,
      output logic win);
    dout = '0;
    @(posedge clk_i);
    select_n_o <= 1'b0;
    sdi_o <= din[n-1];
    hw(10);
    win = sdo_oe_i ? sdo_i : 1'bz;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= din[i];
      sclk_o <= 1'b1;
      hw(10);
      dout[i] = sdo_oe_i ? sdo_i : 1'bz;
      sclk_o <= 1'b0;
      hw(10);
    end
    select_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    hw(10);
  endtask
endmodule
`default_nettype wire

// ---- bench/rsd_top_bench.sv ----
// testbench: serial link and bus scenarios for rsd_top
`timescale 1ns/1ps
`default_nettype none
module rsd_top_bench
  import rsd_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [7:0] input_pin_i = '0;
  rsd_sense_t [7:0] sense_i = '0;
  wire logic select_n_i, sclk_i, sdi_i, sdo_o, sdo_oe_o, wb_ack_o;
  wire logic [31:0] wb_dat_o;
  rsd_drive_t [7:0] drive_o;
  logic [31:0] q, dout;
  logic win;
  int error_cnt = 0;
  int cmp_count = 0;
  always #4 clk_i = ~clk_i;
  rsd_top i_rsd_top (.clk_i, .rst_i, .select_n_i, .sclk_i, .sdi_i, .sdo_o, .sdo_oe_o,
    .input_pin_i, .sense_i, .drive_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o);
  rsd_spi_master i_rsd_spi_master (.clk_i, .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o),
    .select_n_o(select_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i));
  // ==========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, 8'h10, 32'h1234);
    wb(1'b0, RSD_ADDR_CONFIG, 0);
    chk(q, 32'hffff);
    wb(1'b0, 8'h10, 0);
    chk(q, 0);
    wb(1'b0, RSD_ADDR_STATUS, 0);
    chk(32'(q[0]), 1);
    i_rsd_spi_master.xfer(16, 0, dout, win);
    chk(32'(win), 1);
    chk(dout, 0);
    wb(1'b0, RSD_ADDR_CONFIG, 0);
    chk(q, 0);
    i_rsd_spi_master.xfer(12, 32'hfff, dout, win);
    chk(32'(win), 1);
    wb(1'b0, RSD_ADDR_CONFIG, 0);
    chk(q, 0);
    wb(1'b0, RSD_ADDR_STATUS, 0);
    chk(32'(q[0]), 1);
    // ch0 off, ch1 on, ch3 on, ch4 follows pin
    i_rsd_spi_master.xfer(16, 32'h018b, dout, win);
    chk(32'(win), 1);
    input_pin_i <= 8'h10;
    // ch0..2 open load, ch1 over load, ch3 hot
    sense_i <= 24'h000334;
    repeat (4000) @(posedge clk_i);
    chk(32'({drive_o[4].switch_on, drive_o[3].switch_on, drive_o[1].switch_on,
      drive_o[0].diag_current}), 32'h9);
    wb(1'b0, RSD_ADDR_FLAGS, 0);
    chk(q, 32'h46);
    wb(1'b0, RSD_ADDR_OUTPUT, 0);
    chk(q, 32'h245);
    i_rsd_spi_master.xfer(24, 32'h5a0000, dout, win);
    chk(32'(win), 0);
    chk(dout, 32'h00465a);
    wb(1'b0, RSD_ADDR_CONFIG, 0);
    chk(q, 0);
    i_rsd_spi_master.xfer(16, 0, dout, win);
    chk(dout, 0);
    sense_i <= '0;
    // reset between two commands
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, RSD_ADDR_STATUS, 0);
    chk(32'(q[0]), 1);
    wb(1'b0, RSD_ADDR_CONFIG, 0);
    chk(q, 32'hffff);
    i_rsd_spi_master.xfer(16, 0, dout, win);
    chk(32'(win), 1);
    chk(dout, 0);
    summarize();
  end
endmodule
`default_nettype wire
